/* File: common/memmap_defs.vh */
`ifndef MEMMAP_DEFS_VH
`define MEMMAP_DEFS_VH
// AHB register offsets (byte addresses)
`define OFF_PAGE_SEL      12'h000
`define OFF_POINTER       12'h004
`define OFF_PC            12'h008
`define OFF_CONST_ADDR    12'h00c
`define OFF_CONST_OUT     12'h010
`define OFF_REG_REQ       12'h014
`define OFF_REG_OUT       12'h018
`define OFF_LINEAR_ADDR   12'h01c
`define OFF_OPCODE        12'h020
`define OFF_OPCODE_STAT   12'h024
// Page-select fields
`define PSEL_PAGE_BIT     0
`define PSEL_TOGGLE_BIT   7
`define PSEL_RSVD_READ    6'h3f
// Reset values
`define RST_PAGE_SEL      8'h00
`define RST_POINTER       8'h00
`define RST_PC            16'h000c
// Bank-independent addresses
`define ADDR_PAGE_SEL     8'hf0
`define ADDR_POINTER      8'hfd
`define ADDR_USER_DATA    8'hfe
`define ADDR_STACK_PTR    8'hff
// Vector area and banks
`define VECTOR_BYTES      16'h000c
`define BANK_CTRL_D       4'hd
`define BANK_CTRL_F       4'hf
// Opcodes of interest
`define OP_LEGACY_LD      8'h82
`define OP_LEGACY_LDI     8'h83
`endif

/* File: hw/reg_addr_decode.v */
`timescale 1ns/1ns
`include "memmap_defs.vh"
// Maps a banked 8-bit register address to a 12-bit linear location
module reg_addr_decode (
  // Request
  input  wire [7:0]  addr,
  input  wire        working,
  input  wire        stack_op,
  input  wire [7:0]  pointer,
  // Result
  output reg  [11:0] linear,
  output reg         port_hole,
  output reg         bad_bank
);
  reg [7:0] a8;
  reg [3:0] bank;
  // Work out the bank after the shared windows are applied
  always @* begin
    a8 = working ? {pointer[7:4], addr[3:0]} : addr;
    bank = pointer[3:0];
    port_hole = 1'b0;
    if (stack_op)
      bank = 4'h0;
    else if (a8 >= 8'hf0)
      bank = 4'h0;
    else if (bank == `BANK_CTRL_D || bank == `BANK_CTRL_F) begin
      if (a8 >= 8'h10)
        bank = 4'h0;
    end else if (a8 <= 8'h03) begin
      bank = 4'h0;
      port_hole = (a8 == 8'h01);
    end
    bad_bank = !(bank <= 4'h3 || bank == `BANK_CTRL_D || bank == `BANK_CTRL_F);
    linear = {bank, a8};
  end
endmodule // reg_addr_decode

/* File: hw/banked_memory_address_map.v */
`timescale 1ns/1ns
`include "memmap_defs.vh"
module banked_memory_address_map #(
  parameter OTP_BYTES = 131072
) (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [11:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  // Memory address outputs
  output reg  [16:0] otp_addr_ff,
  output reg         otp_is_fetch_ff,
  output reg  [11:0] reg_linear_ff,
  output reg         reg_port_hole_ff,
  output reg         reg_bad_bank_ff
);
  // Page 1 exists only on parts with more than one 64 KB page of OTP
  localparam HAS_PAGE1 = (OTP_BYTES > 65536) ? 1 : 0;
  // Architectural registers
  reg [7:0]  page_sel_ff;
  reg [7:0]  pointer_ff;
  reg [7:0]  stack_ptr_ff;
  reg [7:0]  user_data_ff;
  reg [15:0] pc_ff;
  reg [15:0] const_addr_ff;
  reg [16:0] const_out_ff;
  reg [15:0] reg_req_ff;
  reg [11:0] linear_ff;
  reg        opcode_bad_ff;
  reg        lin_mode_ff;
  reg [7:0]  opcode_ff;
  // AHB address phase capture
  reg        wr_pend_ff;
  reg        rd_pend_ff;
  reg [11:0] addr_ff;
  wire       take = hsel && hready && htrans[1];
  // Decoder output
  wire [11:0] dec_linear;
  wire        dec_hole;
  wire        dec_bad;
  reg_addr_decode u_dec (
    .addr     (reg_req_ff[7:0]),
    .working  (reg_req_ff[8]),
    .stack_op (reg_req_ff[9]),
    .pointer  (pointer_ff),
    .linear   (dec_linear),
    .port_hole(dec_hole),
    .bad_bank (dec_bad)
  );
  // Control decodes from write data
  wire wr = wr_pend_ff;
  wire [7:0] wd = hwdata[7:0];
  wire pc_step   = wr && addr_ff == `OFF_PC && hwdata[16];
  wire ldc_go    = wr && addr_ff == `OFF_CONST_ADDR;
  wire ldc_incr  = ldc_go && hwdata[16];
  // An incrementing access reads at the given address, then steps past it
  wire wrap_top  = hwdata[15:0] == 16'hffff;
  wire [15:0] nxt_const_addr = hwdata[15:0] + 16'h0001;
  // Constant page; a single-page part never leaves page 0
  wire const_page = page_sel_ff[`PSEL_PAGE_BIT] && (HAS_PAGE1 != 0);
  // Jumps into the vector area are redirected past it
  wire [15:0] pc_load = (hwdata[15:0] < `VECTOR_BYTES) ? `VECTOR_BYTES : hwdata[15:0];
  // Bank-independent register writes through the decoded linear address
  wire lin_wr = wr && addr_ff == `OFF_REG_OUT;
  wire lin_addr_wr = wr && addr_ff == `OFF_LINEAR_ADDR;
  // Reserved-bank test for the linear path, which skips the window decoder
  wire [3:0] lin_bank = lin_addr_wr ? hwdata[11:8] : linear_ff[11:8];
  wire lin_bad = !(lin_bank <= 4'h3 || lin_bank == `BANK_CTRL_D ||
                   lin_bank == `BANK_CTRL_F);
  // AHB handshake: one wait-free data phase
  always @(posedge clk) begin
    if (sys_rst) begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      addr_ff    <= 12'h000;
      hreadyout  <= 1'b1;
      hresp      <= 1'b0;
    end else begin
      wr_pend_ff <= take && hwrite;
      rd_pend_ff <= take && !hwrite;
      if (take)
        addr_ff <= {haddr[11:2], 2'b00};
    end
  end
  // Read data, registered so it follows the address phase by one edge
  always @(posedge clk) begin
    if (sys_rst)
      hrdata <= 32'h0000_0000;
    else if (take && !hwrite) begin
      case ({haddr[11:2], 2'b00})
        `OFF_PAGE_SEL:    hrdata <= {24'h0, page_sel_ff[7], `PSEL_RSVD_READ,
                                     page_sel_ff[0]};
        `OFF_POINTER:     hrdata <= {24'h0, pointer_ff};
        `OFF_PC:          hrdata <= {16'h0, pc_ff};
        `OFF_CONST_ADDR:  hrdata <= {16'h0, const_addr_ff};
        `OFF_CONST_OUT:   hrdata <= {15'h0, const_out_ff};
        `OFF_REG_REQ:     hrdata <= {16'h0, reg_req_ff};
        `OFF_REG_OUT:     hrdata <= {20'h0, reg_linear_ff};
        `OFF_LINEAR_ADDR: hrdata <= {20'h0, linear_ff};
        `OFF_OPCODE:      hrdata <= {24'h0, stack_ptr_ff};
        `OFF_OPCODE_STAT: hrdata <= {15'h0, opcode_bad_ff, user_data_ff, opcode_ff};
        default:          hrdata <= 32'h0000_0000;
      endcase
    end
  end
  // Program counter: fetch always from page 0
  always @(posedge clk) begin
    if (sys_rst) begin
      pc_ff           <= `RST_PC;
      otp_addr_ff     <= {1'b0, `RST_PC};
      otp_is_fetch_ff <= 1'b1;
    end else if (pc_step) begin
      pc_ff           <= pc_ff + 16'h0001;
      otp_addr_ff     <= {1'b0, pc_ff + 16'h0001};
      otp_is_fetch_ff <= 1'b1;
    end else if (wr && addr_ff == `OFF_PC) begin
      // Fetch address follows the redirected counter, never a vector byte
      pc_ff           <= pc_load;
      otp_addr_ff     <= {1'b0, pc_load};
      otp_is_fetch_ff <= 1'b1;
    end else if (ldc_go) begin
      otp_addr_ff     <= {const_page, hwdata[15:0]};
      otp_is_fetch_ff <= 1'b0;
    end
  end
  // Constant address and page select with toggle
  always @(posedge clk) begin
    if (sys_rst) begin
      page_sel_ff   <= `RST_PAGE_SEL;
      const_addr_ff <= 16'h0000;
      const_out_ff  <= 17'h00000;
    end else begin
      if (wr && addr_ff == `OFF_PAGE_SEL)
        page_sel_ff <= {wd[7], 6'h00, wd[0]};
      else if (lin_wr && reg_linear_ff == {4'h0, `ADDR_PAGE_SEL})
        page_sel_ff <= {wd[7], 6'h00, wd[0]};
      else if (ldc_incr && wrap_top && page_sel_ff[`PSEL_TOGGLE_BIT])
        page_sel_ff[`PSEL_PAGE_BIT] <= ~page_sel_ff[`PSEL_PAGE_BIT];
      if (ldc_go) begin
        // Increment wraps inside the page; toggle handled above
        const_addr_ff <= ldc_incr ? nxt_const_addr : hwdata[15:0];
        const_out_ff  <= {const_page, hwdata[15:0]};
      end
    end
  end
  // Pointer, stack pointer, user byte
  always @(posedge clk) begin
    if (sys_rst) begin
      pointer_ff   <= `RST_POINTER;
      stack_ptr_ff <= 8'h00;
      user_data_ff <= 8'h00;
    end else begin
      if (wr && addr_ff == `OFF_POINTER)
        pointer_ff <= wd;
      else if (lin_wr && reg_linear_ff == {4'h0, `ADDR_POINTER})
        pointer_ff <= wd;
      if (lin_wr && reg_linear_ff == {4'h0, `ADDR_STACK_PTR})
        stack_ptr_ff <= wd;
      if (lin_wr && reg_linear_ff == {4'h0, `ADDR_USER_DATA})
        user_data_ff <= wd;
    end
  end
  // Register request and decoded result
  always @(posedge clk) begin
    if (sys_rst) begin
      reg_req_ff       <= 16'h0000;
      reg_linear_ff    <= 12'h000;
      reg_port_hole_ff <= 1'b0;
      reg_bad_bank_ff  <= 1'b0;
      linear_ff        <= 12'h000;
      lin_mode_ff      <= 1'b0;
    end else begin
      if (wr && addr_ff == `OFF_REG_REQ)
        reg_req_ff <= hwdata[15:0];
      else if (lin_addr_wr)
        linear_ff <= hwdata[11:0];
      // A linear address holds until the next banked request replaces it
      if (wr && addr_ff == `OFF_REG_REQ)
        lin_mode_ff <= 1'b0;
      else if (lin_addr_wr)
        lin_mode_ff <= 1'b1;
      if (lin_addr_wr || lin_mode_ff) begin
        // Linear path bypasses windows so hidden bytes stay reachable
        reg_linear_ff    <= lin_addr_wr ? hwdata[11:0] : linear_ff;
        reg_port_hole_ff <= 1'b0;
        reg_bad_bank_ff  <= lin_bad;
      end else begin
        reg_linear_ff    <= dec_linear;
        reg_port_hole_ff <= dec_hole;
        reg_bad_bank_ff  <= dec_bad;
      end
    end
  end
  // Opcode check for legacy external loads
  always @(posedge clk) begin
    if (sys_rst) begin
      opcode_ff     <= 8'h00;
      opcode_bad_ff <= 1'b0;
    end else if (wr && addr_ff == `OFF_OPCODE) begin
      opcode_ff     <= wd;
      opcode_bad_ff <= (wd == `OP_LEGACY_LD) || (wd == `OP_LEGACY_LDI);
    end
  end
endmodule // banked_memory_address_map

/* File: sim/banked_memory_address_map_props.sv */
`timescale 1ns/1ns
// Port-level checks on the address map block
module banked_memory_address_map_props #(
  parameter OTP_BYTES = 131072
) (
  // Clock, reset and bus
  input wire        clk,
  input wire        sys_rst,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hwrite,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  // Decoded outputs
  input wire [16:0] otp_addr_ff,
  input wire        otp_is_fetch_ff,
  input wire [11:0] reg_linear_ff,
  input wire        reg_port_hole_ff,
  input wire        reg_bad_bank_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Three edges with no transfer taken
  sequence s_quiet;
    !(hsel && hready && htrans[1]) [*3];
  endsequence
  a_reset_vector: assert property ($past(sys_rst) |-> otp_addr_ff == 17'h0000c && otp_is_fetch_ff)
    else $error("fetch not at reset vector");
  a_fetch_page0: assert property (otp_is_fetch_ff |-> !otp_addr_ff[16])
    else $error("fetch from page 1");
  a_port_hole: assert property (reg_port_hole_ff |-> reg_linear_ff == 12'h001)
    else $error("port hole off address 01");
  a_bad_bank: assert property (reg_bad_bank_ff == !(reg_linear_ff[11:8] inside
    {4'h0, 4'h1, 4'h2, 4'h3, 4'hd, 4'hf}))
    else $error("reserved bank flag wrong");
  a_ready_high: assert property (hreadyout) else $error("wait state seen");
  a_resp_okay: assert property (!hresp) else $error("error response seen");
  a_rdata_hold: assert property (!$past(hsel && hready && htrans[1] && !hwrite)
    && !$past(sys_rst) |-> $stable(hrdata)) else $error("read data moved");
  a_idle_stable: assert property (s_quiet |=> $stable(reg_linear_ff) && $stable(otp_addr_ff))
    else $error("decode moved without a request");
endmodule // banked_memory_address_map_props
bind banked_memory_address_map banked_memory_address_map_props #(.OTP_BYTES(OTP_BYTES)) u_props (
  .clk(clk), .sys_rst(sys_rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
  .otp_addr_ff(otp_addr_ff), .otp_is_fetch_ff(otp_is_fetch_ff),
  .reg_linear_ff(reg_linear_ff), .reg_port_hole_ff(reg_port_hole_ff),
  .reg_bad_bank_ff(reg_bad_bank_ff));

/* File: sim/cpu_core_model.sv */
`timescale 1ns/1ns
// Core-side bus master; each request is held until the slave is ready or the shared 20-cycle wait bound runs out
module cpu_core_model (
  // Bus
  input  wire         clk,
  input  wire         hreadyout,
  input  wire  [31:0] hrdata,
  output logic        hsel,
  output logic [11:0] haddr,
  output logic [1:0]  htrans,
  output logic        hwrite,
  output logic [2:0]  hsize,
  output logic [31:0] hwdata,
  output logic        tmo
);
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata, tmo} = '0;
    hsize = 3'h2;
  end
  // Bounded wait so a stuck slave cannot hang the run
  task wait_rdy(inout int n);
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 20) begin
      n++;
      @(posedge clk);
    end
  endtask
  // One single word transfer, started right after a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] q);
    int n;
    n = 0;
    hsel <= 1'b1; haddr <= a; hwrite <= w; htrans <= 2'h2;
    wait_rdy(n);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    wait_rdy(n);
    q = hrdata;
    if (n >= 20) tmo = 1'b1;
  endtask
endmodule // cpu_core_model

/* File: sim/banked_memory_address_map_tb_top.sv */
`timescale 1ns/1ns
module banked_memory_address_map_tb_top;
  logic        clk, sys_rst, hsel, hwrite, tmo, hreadyout, hresp, fetch, hole, bad;
  logic [11:0] haddr, lin;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, q;
  logic [16:0] otp;
  int          errors, num_checks;
  // Pointer, request and expected linear address; only legal banks are selected
  logic [31:0] tab [10] = '{32'h00001001, 32'h02050250, 32'h020f50f5, 32'h02002002,
    32'h0d002d02, 32'h0d020020, 32'h73105375, 32'hf21030f3, 32'h03240040, 32'h0f005f05};
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  cpu_core_model u_cpu_core_model (.clk(clk), .hreadyout(hreadyout), .hrdata(hrdata),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .tmo(tmo));
  banked_memory_address_map u_banked_memory_address_map (.clk(clk), .sys_rst(sys_rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .otp_addr_ff(otp), .otp_is_fetch_ff(fetch), .reg_linear_ff(lin),
    .reg_port_hole_ff(hole), .reg_bad_bank_ff(bad));
  task end_sim;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    u_cpu_core_model.xfer(1'b1, a, d, q);
    if (tmo) begin
      errors++;
      end_sim;
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    u_cpu_core_model.xfer(1'b0, a, 32'h0, q);
    if (tmo) begin
      errors++;
      end_sim;
    end
    chk("read", e, q);
  endtask
  // Decoded outputs land one cycle after the request register
  task settle;
    repeat (2) @(posedge clk);
  endtask
  initial begin
    errors = 0;
    num_checks = 0;
    sys_rst = 1'b1;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("otp", 32'h2000c, {fetch, otp});
    rd(12'h000, 32'h7e);
    rd(12'h004, 32'h0);
    rd(12'h030, 32'h0);
    wr(12'h008, 32'hfffe);
    wr(12'h008, 32'h10000);
    settle;
    chk("otp", 32'h2ffff, {fetch, otp});
    wr(12'h008, 32'h10000);
    settle;
    chk("otp", 32'h20000, {fetch, otp});
    wr(12'h008, 32'h5);
    settle;
    chk("otp", 32'h2000c, {fetch, otp});
    wr(12'h000, 32'h80);
    wr(12'h00c, 32'h1ffff);
    rd(12'h000, 32'hff);
    wr(12'h00c, 32'h1234);
    settle;
    chk("otp", 32'h11234, {fetch, otp});
    rd(12'h010, 32'h11234);
    wr(12'h000, 32'h0);
    wr(12'h00c, 32'h1ffff);
    rd(12'h000, 32'h7e);
    rd(12'h00c, 32'h0);
    wr(12'h00c, 32'habcd);
    settle;
    chk("otp", 32'h0abcd, {fetch, otp});
    foreach (tab[i]) begin
      wr(12'h004, {24'h0, tab[i][31:24]});
      wr(12'h014, {20'h0, tab[i][23:12]});
      settle;
      chk("linear", {20'h0, tab[i][11:0]}, {20'h0, lin});
      chk("hole", {31'h0, tab[i][11:0] == 12'h001}, {31'h0, hole});
      chk("bad", 32'h0, {31'h0, bad});
    end
    wr(12'h01c, 32'h1f5);
    settle;
    chk("linear", 32'h1f5, {20'h0, lin});
    rd(12'h018, 32'h1f5);
    wr(12'h004, 32'h0);
    wr(12'h014, 32'hfe);
    settle;
    wr(12'h018, 32'h5a);
    wr(12'h020, 32'h82);
    rd(12'h024, 32'h15a82);
    wr(12'h020, 32'h83);
    rd(12'h024, 32'h15a83);
    wr(12'h020, 32'h12);
    rd(12'h024, 32'h05a12);
    // Stack operation lands on bank 0 FFh whatever the bank nibble holds
    wr(12'h004, 32'h03);
    wr(12'h014, 32'h2ff);
    settle;
    chk("linear", 32'h0ff, {20'h0, lin});
    wr(12'h018, 32'h33);
    rd(12'h020, 32'h33);
    rd(12'h024, 32'h05a12);
    // Second reset in mid-run must bring back the reset values
    wr(12'h004, 32'h12);
    wr(12'h000, 32'h81);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk("otp", 32'h2000c, {fetch, otp});
    rd(12'h000, 32'h7e);
    rd(12'h004, 32'h0);
    end_sim;
  end
endmodule // banked_memory_address_map_tb_top
